/* File: design/mfc_cfg.svh */
`ifndef MFC_CFG_SVH
`define MFC_CFG_SVH

// Datapath widths.
`define MFC_DATA_W 12
`define MFC_COEF_W 10
`define MFC_CAS_W 16
`define MFC_PROD_W 22
`define MFC_ROW_W 24
`define MFC_SUM_W 27
`define MFC_TAPS 9

// Cascade word alignment against the sum of products (4 fraction bits).
`define MFC_CAS_FRAC 4
`define MFC_OUT_MSB 19
`define MFC_OUT_LSB 4
`define MFC_ROUND_VAL 27'h000_0008

// Coefficient write select codes.
`define MFC_CW_HOLD 2'h0
`define MFC_CW_TAP1 2'h1
`define MFC_CW_TAP2 2'h2
`define MFC_CW_TAP3 2'h3

// Clocks in the new configuration before the output is trusted again.
`define MFC_FLUSH_CYCLES 4'hd

// Register map and fields.
`define MFC_ADR_CTRL 8'h00
`define MFC_ADR_STATUS 8'h04
`define MFC_CTRL_CASZ_BIT 0
`define MFC_STAT_SETTLED_BIT 2
`define MFC_CTRL_RST 1'h0

`endif

/* File: design/mfc_coef_bank.sv */
`timescale 1ns/1ps
`include "mfc_cfg.svh"

// Nine coefficient registers, written one tap column at a time.
module mfc_coef_bank (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [1:0] coef_write_select_i,
	input wire logic [`MFC_COEF_W-1:0] coef_port_row_a_i,
	input wire logic [`MFC_COEF_W-1:0] coef_port_row_b_i,
	input wire logic [`MFC_COEF_W-1:0] coef_port_row_c_i,
	output logic [`MFC_TAPS*`MFC_COEF_W-1:0] coef_flat_o
);
	// Slot order per row is tap 3, tap 2, tap 1, matching the window.
	logic [`MFC_COEF_W-1:0] coef_r [0:`MFC_TAPS-1];
	logic [`MFC_COEF_W-1:0] row_port [0:2];

	assign row_port[0] = coef_port_row_a_i;
	assign row_port[1] = coef_port_row_b_i;
	assign row_port[2] = coef_port_row_c_i;

	// Each port feeds only its own row; the select picks the tap column.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < `MFC_TAPS; i++) begin
				coef_r[i] <= '0;
			end
		end else if (ce_i && coef_write_select_i != `MFC_CW_HOLD) begin
			for (int r = 0; r < 3; r++) begin
				coef_r[r*3 + 3 - int'(coef_write_select_i)] <= row_port[r];
			end
		end
	end

	// Flatten for the datapath, slot 0 in the low bits.
	always_comb begin
		for (int i = 0; i < `MFC_TAPS; i++) begin
			coef_flat_o[i*`MFC_COEF_W +: `MFC_COEF_W] = coef_r[i];
		end
	end

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	// A hold select leaves every register untouched.
	property p_coef_hold;
		(ce_i && coef_write_select_i == `MFC_CW_HOLD) |=> $stable(coef_flat_o);
	endproperty
	a_coef_hold: assert property (p_coef_hold) else $error("coef changed on hold");

	// Tap 1 select loads the row ports into the tap 1 slots only.
	property p_coef_tap1;
		(ce_i && coef_write_select_i == `MFC_CW_TAP1) |=>
			coef_r[2] == $past(coef_port_row_a_i) && coef_r[5] == $past(coef_port_row_b_i)
			&& coef_r[8] == $past(coef_port_row_c_i) && $stable(coef_r[0]) && $stable(coef_r[4]);
	endproperty
	a_coef_tap1: assert property (p_coef_tap1) else $error("tap1 write wrong");

	// Tap 3 select loads the tap 3 slots.
	property p_coef_tap3;
		(ce_i && coef_write_select_i == `MFC_CW_TAP3) |=>
			coef_r[0] == $past(coef_port_row_a_i) && coef_r[6] == $past(coef_port_row_c_i)
			&& $stable(coef_r[7]);
	endproperty
	a_coef_tap3: assert property (p_coef_tap3) else $error("tap3 write wrong");
endmodule : mfc_coef_bank

/* File: design/mfc_convolver.sv */
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "mfc_cfg.svh"

module mfc_convolver (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [1:0] config_select_i,
	input wire logic [1:0] coef_write_select_i,
	input wire logic [`MFC_DATA_W-1:0] data_a_i,
	input wire logic [`MFC_DATA_W-1:0] data_b_i,
	input wire logic [`MFC_DATA_W-1:0] data_c_i,
	input wire logic [`MFC_COEF_W-1:0] coef_port_row_a_i,
	input wire logic [`MFC_COEF_W-1:0] coef_port_row_b_i,
	input wire logic [`MFC_COEF_W-1:0] coef_port_row_c_i,
	input wire logic [11:0] shared_port_first_i,
	input wire logic [3:0] shared_port_mid_upper_i,
	output logic [3:0] shared_port_mid_lower_o,
	output logic [11:0] shared_port_last_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	mfc_pkg::config_t config_r;
	logic [3:0] settle_cnt_r;
	logic casz_r;
	logic ack_r;
	logic [31:0] dat_r;
	logic signed [`MFC_DATA_W-1:0] win_r [0:`MFC_TAPS-1];
	logic signed [`MFC_DATA_W-1:0] b_dly_r [0:2];
	logic signed [`MFC_PROD_W-1:0] prod_r [0:`MFC_TAPS-1];
	logic signed [`MFC_ROW_W-1:0] psum_r [0:2];
	logic signed [`MFC_CAS_W-1:0] cas_in_r;
	logic signed [`MFC_CAS_W-1:0] cas_d_r;
	logic signed [`MFC_SUM_W-1:0] total_r;
	logic [`MFC_CAS_W-1:0] cas_out_r;
	logic [`MFC_TAPS*`MFC_COEF_W-1:0] coef_flat;
	logic [`MFC_CAS_W-1:0] cas_word;
	logic wb_req;

	// Signed 12-bit sample times signed 10-bit fraction, full precision.
	function automatic logic signed [`MFC_PROD_W-1:0] mul_tap(
		input logic signed [`MFC_DATA_W-1:0] d,
		input logic signed [`MFC_COEF_W-1:0] k
	);
		mul_tap = d * k;
	endfunction : mul_tap

	// Sign-extended sum of three products.
	function automatic logic signed [`MFC_ROW_W-1:0] add3(
		input logic signed [`MFC_PROD_W-1:0] p0,
		input logic signed [`MFC_PROD_W-1:0] p1,
		input logic signed [`MFC_PROD_W-1:0] p2
	);
		add3 = `MFC_ROW_W'(p0) + `MFC_ROW_W'(p1) + `MFC_ROW_W'(p2);
	endfunction : add3

	mfc_coef_bank u_coef (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.coef_write_select_i(coef_write_select_i),
		.coef_port_row_a_i(coef_port_row_a_i),
		.coef_port_row_b_i(coef_port_row_b_i),
		.coef_port_row_c_i(coef_port_row_c_i),
		.coef_flat_o(coef_flat)
	);

	// Cascade input word: first pins high, upper-mid pins low; can be zeroed by software.
	assign cas_word = casz_r ? '0 : {shared_port_first_i, shared_port_mid_upper_i};

	// Configuration select takes effect from the next edge.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			config_r <= mfc_pkg::CFG_FIR9;
		end else if (ce_i) begin
			config_r <= mfc_pkg::config_t'(config_select_i);
		end
	end

	// Counts clocks spent in the current configuration until the pipeline is flushed.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			settle_cnt_r <= '0;
		end else if (ce_i) begin
			if (config_select_i != config_r) begin
				settle_cnt_r <= '0;
			end else if (settle_cnt_r != `MFC_FLUSH_CYCLES) begin
				settle_cnt_r <= settle_cnt_r + 4'h1;
			end
		end
	end

	// Row B of the FIR is fed through three delays so it carries the older samples.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 3; i++) begin
				b_dly_r[i] <= '0;
			end
		end else if (ce_i) begin
			b_dly_r[0] <= data_b_i;
			b_dly_r[1] <= b_dly_r[0];
			b_dly_r[2] <= b_dly_r[1];
		end
	end

	// Multiplier input window; slot 0 is the newest sample of row A.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < `MFC_TAPS; i++) begin
				win_r[i] <= '0;
			end
		end else if (ce_i) begin
			case (config_r)
				mfc_pkg::CFG_FIR9: begin
					win_r[0] <= data_a_i;
					win_r[1] <= win_r[0];
					win_r[2] <= win_r[1];
					win_r[3] <= b_dly_r[2];
					win_r[4] <= win_r[3];
					win_r[5] <= win_r[4];
					win_r[6] <= win_r[5];
					win_r[7] <= win_r[6];
					win_r[8] <= win_r[7];
				end
				mfc_pkg::CFG_CONV33: begin
					for (int r = 0; r < 3; r++) begin
						win_r[r*3+1] <= win_r[r*3];
						win_r[r*3+2] <= win_r[r*3+1];
					end
					win_r[0] <= data_a_i;
					win_r[3] <= data_b_i;
					win_r[6] <= data_c_i;
				end
				mfc_pkg::CFG_CONV42: begin
					win_r[0] <= data_a_i;
					win_r[1] <= win_r[0];
					win_r[2] <= win_r[1];
					win_r[6] <= win_r[2];
					win_r[3] <= data_b_i;
					win_r[4] <= win_r[3];
					win_r[5] <= win_r[4];
					win_r[8] <= win_r[5];
					win_r[7] <= '0;
				end
				default: begin
					win_r[0] <= data_a_i;
					win_r[3] <= data_b_i;
					win_r[6] <= data_c_i;
				end
			endcase
		end
	end

	// Stage 1: products and the captured cascade input.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < `MFC_TAPS; i++) begin
				prod_r[i] <= '0;
			end
			cas_in_r <= '0;
		end else if (ce_i) begin
			for (int i = 0; i < `MFC_TAPS; i++) begin
				if (i == 7 && config_r == mfc_pkg::CFG_CONV42) begin
					prod_r[i] <= '0;
				end else begin
					prod_r[i] <= mul_tap(win_r[i], coef_flat[i*`MFC_COEF_W +: `MFC_COEF_W]);
				end
			end
			cas_in_r <= cas_word;
		end
	end

	// Stage 2: row sums, cascade input delayed alongside.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			for (int r = 0; r < 3; r++) begin
				psum_r[r] <= '0;
			end
			cas_d_r <= '0;
		end else if (ce_i) begin
			for (int r = 0; r < 3; r++) begin
				psum_r[r] <= add3(prod_r[r*3], prod_r[r*3+1], prod_r[r*3+2]);
			end
			cas_d_r <= cas_in_r;
		end
	end

	// Stage 3: full sum, aligned cascade word and half-LSB rounding constant.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			total_r <= '0;
		end else if (ce_i) begin
			total_r <= `MFC_SUM_W'(psum_r[0]) + `MFC_SUM_W'(psum_r[1]) + `MFC_SUM_W'(psum_r[2])
				+ `MFC_SUM_W'($signed({cas_d_r, 4'h0})) + `MFC_ROUND_VAL;
		end
	end

	// Stage 4: keep result bits 19:4, wrapping on overflow, every enabled clock.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cas_out_r <= '0;
		end else if (ce_i) begin
			cas_out_r <= total_r[`MFC_OUT_MSB:`MFC_OUT_LSB];
		end
	end

	// Cascade output word: last pins high, lower-mid pins low.
	assign shared_port_last_o = cas_out_r[15:4];
	assign shared_port_mid_lower_o = cas_out_r[3:0];

	// Register slave: one wait state, every address answered, unmapped reads zero.
	assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= '0;
			casz_r <= `MFC_CTRL_RST;
		end else if (ce_i) begin
			ack_r <= wb_req;
			if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `MFC_ADR_CTRL) begin
				casz_r <= wb_dat_i[`MFC_CTRL_CASZ_BIT];
			end
			if (wb_req && !wb_we_i) begin
				if (wb_adr_i == `MFC_ADR_CTRL) begin
					dat_r <= {31'h0000_0000, casz_r};
				end else if (wb_adr_i == `MFC_ADR_STATUS) begin
					dat_r <= {29'h0000_0000, settle_cnt_r == `MFC_FLUSH_CYCLES, config_r};
				end else begin
					dat_r <= '0;
				end
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	// Two enabled edges in a row.
	sequence s_run2;
		ce_i ##1 ce_i;
	endsequence

	property p_cfg_next_edge;
		ce_i |=> config_r == $past(config_select_i);
	endproperty
	a_cfg_next_edge: assert property (p_cfg_next_edge) else $error("config not registered");

	property p_fir_shift;
		(ce_i && config_r == mfc_pkg::CFG_FIR9) |=>
			win_r[1] == $past(win_r[0]) && win_r[6] == $past(win_r[5]) && win_r[0] == $past(data_a_i);
	endproperty
	a_fir_shift: assert property (p_fir_shift) else $error("fir shift wrong");

	property p_fir_b_row;
		(s_run2 ##1 ce_i ##1 (ce_i && config_r == mfc_pkg::CFG_FIR9)) |=>
			win_r[3] == $past(data_b_i, 4);
	endproperty
	a_fir_b_row: assert property (p_fir_b_row) else $error("fir row B delay wrong");

	property p_conv33_shift;
		(ce_i && config_r == mfc_pkg::CFG_CONV33) |=>
			win_r[7] == $past(win_r[6]) && win_r[6] == $past(data_c_i) && win_r[5] == $past(win_r[4]);
	endproperty
	a_conv33_shift: assert property (p_conv33_shift) else $error("3x3 shift wrong");

	property p_conv42_shift;
		(ce_i && config_r == mfc_pkg::CFG_CONV42) |=>
			win_r[4] == $past(win_r[3]) && win_r[8] == $past(win_r[5]) && win_r[6] == $past(win_r[2]);
	endproperty
	a_conv42_shift: assert property (p_conv42_shift) else $error("4x2 shift wrong");

	property p_kc2_ignored;
		(ce_i && config_r == mfc_pkg::CFG_CONV42) |=> prod_r[7] == '0;
	endproperty
	a_kc2_ignored: assert property (p_kc2_ignored) else $error("unused tap used");

	property p_cas_path;
		s_run2 |=> cas_d_r == $past(cas_word, 2);
	endproperty
	a_cas_path: assert property (p_cas_path) else $error("cascade delay wrong");

	property p_cas_out_pins;
		ce_i |=> {shared_port_last_o, shared_port_mid_lower_o} == $past(total_r[19:4]);
	endproperty
	a_cas_out_pins: assert property (p_cas_out_pins) else $error("cascade out wrong");

	property p_unsettled;
		(ce_i && config_select_i != config_r) |=> settle_cnt_r == 4'h0;
	endproperty
	a_unsettled: assert property (p_unsettled) else $error("flush count not restarted");

	property p_ack_once;
		(ack_r && ce_i) |=> !ack_r;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack held");

	// A request taken on an enabled edge is answered at the next edge.
	property p_ack_answer;
		(ce_i && wb_req) |=> wb_ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("request not answered");

	// A low clock enable freezes the pipeline, the configuration and the flush count.
	property p_freeze;
		!ce_i |=> $stable(cas_out_r) && $stable(config_r) && $stable(settle_cnt_r);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");

	// Once flushed, the count stays saturated while the configuration holds.
	property p_settled_hold;
		(ce_i && config_select_i == config_r && settle_cnt_r == `MFC_FLUSH_CYCLES) |=>
			settle_cnt_r == `MFC_FLUSH_CYCLES;
	endproperty
	a_settled_hold: assert property (p_settled_hold) else $error("flush count dropped");

	// The 3x3 window loads one new pixel into the head of row A and of row B.
	property p_conv33_load;
		(ce_i && config_r == mfc_pkg::CFG_CONV33) |=>
			win_r[0] == $past(data_a_i) && win_r[3] == $past(data_b_i);
	endproperty
	a_conv33_load: assert property (p_conv33_load) else $error("3x3 load wrong");
endmodule : mfc_convolver

/* File: design/mfc_pkg.sv */
package mfc_pkg;
	// Configuration select, in select code order 00, 01, 10, 11.
	typedef enum logic [1:0] {
		CFG_MATRIX,
		CFG_FIR9,
		CFG_CONV33,
		CFG_CONV42
	} config_t;
endpackage : mfc_pkg

/* File: testbench/mfc_src_model.sv */
`timescale 1ns/1ps

// Upstream pipeline: streams random samples and cascade words into the filter.
module mfc_src_model (
	input wire logic clock_i,
	input wire logic run_i,
	input wire logic [1:0] cfg_i,
	output logic [11:0] data_a_o,
	output logic [11:0] data_b_o,
	output logic [11:0] data_c_o,
	output logic [15:0] cas_o
);
	int seed = 32'h96a7;
	logic [11:0] smp;

	// Start from defined words so the filter never sees an unknown sample.
	initial begin
		data_a_o = 12'h000;
		data_b_o = 12'h000;
		data_c_o = 12'h000;
		cas_o = 16'h0000;
	end

	// A new word each clock while running; a held word models a slow upstream.
	always @(posedge clock_i) begin
		if (run_i) begin
			smp = 12'($random(seed));
			data_a_o <= smp;
			data_b_o <= (cfg_i == 2'h1) ? smp : 12'($random(seed));
			data_c_o <= 12'($random(seed));
			cas_o <= 16'($random(seed)) | ((cfg_i == 2'h2) ? 16'h0008 : 16'h0000);
		end
	end
endmodule : mfc_src_model

/* File: testbench/tb_multimode_fir_convolver.sv */
`timescale 1ns/1ps
`include "mfc_cfg.svh"

`define TB_CHECK(got, exp) begin \
	n_tests++; \
	if ((got) !== (exp)) begin \
		err_total++; \
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
	end \
end

module tb_multimode_fir_convolver;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic [1:0] cfg = 2'h1;
	logic [1:0] cws = 2'h0;
	logic [9:0] ka = 10'h000;
	logic [9:0] kb = 10'h000;
	logic [9:0] kc = 10'h000;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack;
	logic src_run = 1'b1;
	logic [11:0] da, db, dc, last;
	logic [15:0] cas;
	logic [3:0] midlo;
	logic [15:0] exp_q[$];
	logic [31:0] rd_q[$];
	logic [15:0] e16;
	logic [15:0] e_hold;
	logic [31:0] e32;
	logic zero_cas = 1'b0;
	logic zc_prev = 1'b0;
	logic [1:0] cur = 2'h1;
	int seed = 32'h96a7;
	int err_total = 0;
	int n_tests = 0;
	int n = 0;
	int stable = 0;
	int ha[256], hb[256], hc[256], hs[256];
	int k[3][3];

	// Clock of 200 MHz.
	always #2.5 clock_i = ~clock_i;

	mfc_src_model u_src (
		.clock_i(clock_i), .run_i(src_run), .cfg_i(cfg),
		.data_a_o(da), .data_b_o(db), .data_c_o(dc), .cas_o(cas)
	);

	mfc_convolver u_dut (
		.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
		.config_select_i(cfg), .coef_write_select_i(cws),
		.data_a_i(da), .data_b_i(db), .data_c_i(dc),
		.coef_port_row_a_i(ka), .coef_port_row_b_i(kb), .coef_port_row_c_i(kc),
		.shared_port_first_i(cas[15:4]), .shared_port_mid_upper_i(cas[3:0]),
		.shared_port_mid_lower_o(midlo), .shared_port_last_o(last),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack)
	);

	// Returns a sampled word of one row or the cascade, the given number of enabled edges back.
	function automatic int at(input int r, input int d);
		int i;
		i = (n - d) & 255;
		return (r == 0) ? ha[i] : (r == 1) ? hb[i] : (r == 2) ? hc[i] : hs[i];
	endfunction : at

	// Reference model: records each enabled sample and predicts the cascade output.
	always @(posedge clock_i) begin
		int s;
		if (rst_i) begin
			stable = 0;
			cur = 2'h1;
			k = '{default: 0};
		end else if (!ce_i) begin
			// A frozen pipeline holds its last word on the output.
			if (stable >= 16 && cur != 2'h0) exp_q.push_back(e_hold);
		end else begin
			n++;
			ha[n & 255] = $signed(da);
			hb[n & 255] = $signed(db);
			hc[n & 255] = $signed(dc);
			hs[n & 255] = zero_cas ? 0 : $signed(cas);
			if (cws != 2'h0) begin
				k[0][cws - 1] = $signed(ka);
				k[1][cws - 1] = $signed(kb);
				k[2][cws - 1] = $signed(kc);
				stable = 0;
			end else if (cfg != cur || zero_cas != zc_prev) begin
				stable = 0;
			end else begin
				stable++;
			end
			cur = cfg;
			zc_prev = zero_cas;
			if (stable >= 16 && cur != 2'h0) begin
				s = 8 + (at(3, 3) << 4);
				for (int t = 0; t < 3; t++) begin
					if (cur == 2'h1) begin
						s += at(0, 4 + t) * k[0][2 - t] + at(1, 7 + t) * k[1][2 - t];
						s += at(1, 10 + t) * k[2][2 - t];
					end else if (cur == 2'h2) begin
						for (int r = 0; r < 3; r++) s += at(r, 4 + t) * k[r][2 - t];
					end else begin
						s += at(0, 4 + t) * k[0][2 - t] + at(1, 4 + t) * k[1][2 - t];
					end
				end
				if (cur == 2'h3) s += at(0, 7) * k[2][2] + at(1, 7) * k[2][0];
				e_hold = s[19:4];
				exp_q.push_back(e_hold);
			end
		end
	end

	// Monitor: takes the oldest note whenever a result appears.
	always @(negedge clock_i) begin
		if (exp_q.size() > 0) begin
			e16 = exp_q.pop_front();
			`TB_CHECK({last, midlo}, e16)
		end
		if (wb_ack === 1'b1 && rd_q.size() > 0) begin
			e32 = rd_q.pop_front();
			`TB_CHECK(wb_dat_o, e32)
		end
	end

	// One classic bus cycle, held until acknowledge is sampled.
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clock_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_sel <= 4'hf;
		wb_dat <= dat;
		// Only the watchdog ends a wait that never sees acknowledge.
		do begin
			@(posedge clock_i);
		end while (wb_ack !== 1'b1);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask : wb

	// A read whose expected word is noted first.
	task automatic rd(input logic [7:0] adr, input logic [31:0] e);
		rd_q.push_back(e);
		wb(1'b0, adr, 32'h0000_0000);
	endtask : rd

	// Loads all nine coefficients one tap column per clock.
	task automatic load_coefs();
		for (int t = 1; t <= 3; t++) begin
			@(posedge clock_i);
			cws <= 2'(t);
			ka <= 10'($random(seed));
			kb <= 10'($random(seed));
			kc <= 10'($random(seed));
		end
		@(posedge clock_i);
		cws <= 2'h0;
	endtask : load_coefs

	// Streams with upstream stalls, enable freezes and noise on the held coefficient ports.
	task automatic stream(input int cycles);
		repeat (cycles) begin
			@(posedge clock_i);
			src_run <= ($random(seed) % 4 != 0);
			ce_i <= ($random(seed) % 8 != 0);
			ka <= 10'($random(seed));
			kb <= 10'($random(seed));
			kc <= 10'($random(seed));
		end
		@(posedge clock_i);
		src_run <= 1'b1;
		ce_i <= 1'b1;
	endtask : stream

	// Prints the verdict and ends the run.
	task automatic results();
		if (err_total == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	// Watchdog against a hung bus cycle.
	initial begin
		#100000;
		err_total++;
		results();
	end

	// Main sequence.
	initial begin
		repeat (4) @(posedge clock_i);
		rst_i <= 1'b0;
		rd(`MFC_ADR_STATUS, 32'h0000_0001);
		rd(`MFC_ADR_CTRL, 32'h0000_0000);
		wb(1'b1, 8'h08, 32'hffff_ffff);
		rd(8'h08, 32'h0000_0000);
		for (int m = 0; m < 4; m++) begin
			@(posedge clock_i);
			cfg <= 2'(m);
			rd(`MFC_ADR_STATUS, 32'(m));
			load_coefs();
			stream(40);
			rd(`MFC_ADR_STATUS, 32'(m) | 32'h0000_0004);
		end
		wb(1'b1, `MFC_ADR_CTRL, 32'h0000_0001);
		zero_cas <= 1'b1;
		rd(`MFC_ADR_CTRL, 32'h0000_0001);
		stream(40);
		wb(1'b1, `MFC_ADR_CTRL, 32'h0000_0000);
		zero_cas <= 1'b0;
		cfg <= 2'h1;
		load_coefs();
		@(posedge clock_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		rd(`MFC_ADR_STATUS, 32'h0000_0001);
		stream(30);
		results();
	end
endmodule : tb_multimode_fir_convolver
